// File: hw/brac_consts.svh
/*
 * constants for the buffer register assignment and core arbiter block:
 * interval counts, priority codes, timing figures.
 * assumes inclusion by the arbiter package and modules by bare name.
 */
`ifndef BRAC_CONSTS_SVH
`define BRAC_CONSTS_SVH

// global request interval, ns
`define BRAC_REQ_INTERVAL_NS 100
// clock period at 20 mhz, ns
`define BRAC_CLK_PERIOD_NS 50
// clocks per request interval
`define BRAC_CLKS_PER_INTERVAL (`BRAC_REQ_INTERVAL_NS / `BRAC_CLK_PERIOD_NS)
// core cycle length, ns
`define BRAC_CORE_CYCLE_NS 900
// number of quantized intervals, time 0 to time 9
`define BRAC_NUM_INTERVALS 10
// last interval of a normal core cycle
`define BRAC_CORE_LAST_TIME (`BRAC_CORE_CYCLE_NS / `BRAC_REQ_INTERVAL_NS - 1)
// interval counter width
`define BRAC_TIME_W 4
// interval indices named for their role
`define BRAC_TIME0 4'h0
`define BRAC_TIME1 4'h1
`define BRAC_TIME3 4'h3
`define BRAC_TIME4 4'h4
`define BRAC_TIME5 4'h5
`define BRAC_TIME9 4'h9
// core access priority codes {upper, lower}
`define BRAC_PRIO_LOW 2'h0
`define BRAC_PRIO_MEDIUM 2'h2
`define BRAC_PRIO_WARNING 2'h1
`define BRAC_PRIO_HIGH 2'h3
// residence pointer reset value
`define BRAC_PTR_RESET 1'h0

`endif

// File: hw/brac_pkg.sv
/*
 * types for the buffer register assignment and core arbiter block.
 * assumes brac_consts.svh is on the include path.
 */
`include "brac_consts.svh"

package brac_pkg;

    // phase of the 100 ns request interval, one clock each
    typedef enum logic [1:0] {
        BRAC_PH_SAMPLE = 2'h1,
        BRAC_PH_STATUS = 2'h2
    } brac_phase_type;

    // core cycle interval state, time 0..9 counter
    typedef logic [`BRAC_TIME_W-1:0] brac_time_type;

    // state of the top module
    typedef struct packed {
        brac_phase_type phase;
        logic core_cycle_active_a;
        logic core_cycle_active_b;
        logic residence_pointer;
        logic core_running;
        brac_time_type core_time;
    } brac_state_type;

endpackage : brac_pkg

// File: hw/brac_core_timer.sv
/*
 * interval timer: makes the data sample phase and status update strobe
 * of each 100 ns interval, and counts core cycle intervals time 0..9.
 * assumes a 20 mhz ref_clk, two clocks per interval.
 */
`timescale 1ns/10ps

module brac_core_timer
    import brac_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // core cycle start request, seen at the status strobe
    input wire logic core_start,
    // phase outputs
    output logic data_sample_phase,
    output logic status_update_strobe,
    // core cycle state
    output logic core_running,
    output brac_time_type core_time
);

    // timer state
    typedef struct packed {
        brac_phase_type phase;
        logic running;
        brac_time_type ctime;
    } brac_timer_type;

    brac_timer_type st; // registered copy
    brac_timer_type next_st; // next value

    // interval phase and core interval counter
    always_comb begin
        next_st = st;
        unique case (st.phase)
            BRAC_PH_SAMPLE: begin
                next_st.phase = BRAC_PH_STATUS;
            end
            BRAC_PH_STATUS: begin
                next_st.phase = BRAC_PH_SAMPLE;
                // advance a running cycle at each interval end
                if (st.running) begin
                    if (st.ctime == `BRAC_CORE_LAST_TIME) begin
                        next_st.running = 1'h0; // 900 ns elapsed
                        next_st.ctime = `BRAC_TIME9;
                    end else begin
                        next_st.ctime = st.ctime + 4'h1;
                    end
                end else if (core_start) begin
                    next_st.running = 1'h1; // cycle begins at time 0
                    next_st.ctime = `BRAC_TIME0;
                end
            end
            default: begin
                next_st.phase = BRAC_PH_SAMPLE; // illegal code recovery
            end
        endcase
    end

    // register the state
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st.phase <= BRAC_PH_SAMPLE;
            st.running <= 1'h0;
            st.ctime <= `BRAC_TIME9;
        end else begin
            st <= next_st;
        end
    end

    // phase decode
    assign data_sample_phase = (st.phase == BRAC_PH_SAMPLE);
    assign status_update_strobe = (st.phase == BRAC_PH_STATUS);
    assign core_running = st.running;
    assign core_time = st.ctime;

endmodule : brac_core_timer

// File: hw/brac_arbiter.sv
/*
 * control logic of one memory module of a multiport core buffer:
 * register choice for port requests, new allocation marking, residence
 * pointer, availability term, core cycle arbitration between registers
 * a and b, and per-half register write strobes.
 * assumes request and status inputs are stable over each 100 ns interval
 * and synchronous to ref_clk; status bits (hold, sequential, r, c,
 * priority) are kept outside and fed in.
 */
`timescale 1ns/10ps

`include "brac_consts.svh"

// Contract
// - choice needs module request, no store conflict
// - a chosen if free and b busy
// - flag pair plus pointer picks a or b
// - urgent criterion prerequisites on a and b
// - urgent criterion picks a on b condition
// - active or held-sequential register never chosen
// - choice latches status and enables input strobe
// - new allocation when chosen and no match
// - pointer loads a's new allocation
// - availability term forms the accepted response
// - hold flag blocks first-criterion reassignment and store-to-core start
// - active flag set conditions at status strobe
// - a sets if active, b idle, or wins
// - active flag clears at time 1/4/5
// - core cycle spans 900 ns, time 0..8
// - fetch data at 3 or 4, clear later
// - half strobe is sample phase and transfers
// - new store writes chosen a half
// - matching store writes assigned a half
// - locks block accepted and satisfied responses
// - priority coded low 00 medium 10 warning 01 high 11
// - core load sets valid unless reassigned
// - decisions on 100 ns interval, ten intervals
module brac_arbiter
    import brac_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // port request to this module
    input wire logic module_request,
    input wire logic request_is_store,
    input wire logic request_is_fetch,
    input wire logic request_upper_half,
    input wire logic requested_prio_upper,
    input wire logic requested_prio_lower,
    // address match against each register
    input wire logic match_a,
    input wire logic match_b,
    // status of register a
    input wire logic hold_a,
    input wire logic seq_a,
    input wire logic free_a,
    input wire logic [1:0] valid_a,
    input wire logic [1:0] current_a,
    input wire logic latched_prio_upper_a,
    input wire logic latched_prio_lower_a,
    // status of register b
    input wire logic hold_b,
    input wire logic seq_b,
    input wire logic free_b,
    input wire logic [1:0] valid_b,
    input wire logic [1:0] current_b,
    input wire logic latched_prio_upper_b,
    input wire logic latched_prio_lower_b,
    // core module
    input wire logic core_unit_free,
    // choice and assignment
    output logic choose_a,
    output logic choose_b,
    output logic latch_status_a,
    output logic latch_status_b,
    output logic new_allocation_a,
    output logic new_allocation_b,
    output logic residence_pointer,
    output logic free_on_allocation,
    output logic store_conflict_flag,
    // core arbitration
    output logic core_cycle_active_a,
    output logic core_cycle_active_b,
    output logic core_start,
    output logic core_start_scheduled_a,
    output logic core_start_scheduled_b,
    output logic [1:0] core_to_register_load_a,
    output logic [1:0] core_to_register_load_b,
    output logic [1:0] set_valid_a,
    output logic [1:0] set_valid_b,
    output logic core_write_lock,
    output logic core_read_lock,
    output logic core_time_valid,
    output logic [3:0] core_time,
    // data register strobes, bit 1 upper, bit 0 lower
    output logic [1:0] register_write_strobe_a,
    output logic [1:0] register_write_strobe_b,
    output logic [1:0] port_to_register_write_a,
    output logic [1:0] port_to_register_write_b
);

    brac_state_type st; // registered state
    brac_state_type next_st; // next state
    logic data_sample_phase; // register input sample phase
    logic status_update_strobe; // status latch phase
    logic tm_running; // core cycle running
    brac_time_type tm_time; // current core interval

    // interval and core cycle timer
    brac_core_timer u_timer (
        .ref_clk(ref_clk),
        .rst(rst),
        .core_start(core_start),
        .data_sample_phase(data_sample_phase),
        .status_update_strobe(status_update_strobe),
        .core_running(tm_running),
        .core_time(tm_time)
    );

    // per-register need terms
    logic [1:0] fetch_need_a; // c set, r clear: core copy newer
    logic [1:0] fetch_need_b;
    logic [1:0] store_need_a; // r set, c clear: register newer
    logic [1:0] store_need_b;
    logic needs_core_fetch_a; // a must start a core fetch
    logic needs_core_fetch_b;
    logic needs_store_a; // a must store to core
    logic needs_store_b;
    logic stale_a; // register and core copies differ
    logic stale_b;
    logic [1:0] prio_a; // {upper, lower} priority
    logic [1:0] prio_b;
    logic high_request; // requested high priority

    // store versus fetch need per half
    always_comb begin
        fetch_need_a = current_a & ~valid_a;
        fetch_need_b = current_b & ~valid_b;
        store_need_a = valid_a & ~current_a;
        store_need_b = valid_b & ~current_b;
        needs_core_fetch_a = |fetch_need_a;
        needs_core_fetch_b = |fetch_need_b;
        needs_store_a = |store_need_a;
        needs_store_b = |store_need_b;
        stale_a = needs_core_fetch_a | needs_store_a;
        stale_b = needs_core_fetch_b | needs_store_b;
    end

    // priority pairs and high-priority request
    always_comb begin
        prio_a = {latched_prio_upper_a, latched_prio_lower_a};
        prio_b = {latched_prio_upper_b, latched_prio_lower_b};
        high_request = ({requested_prio_upper, requested_prio_lower}
            == `BRAC_PRIO_HIGH);
    end

    // core lock and store conflict
    always_comb begin
        core_write_lock = (|core_to_register_load_a)
            | (|core_to_register_load_b);
        core_read_lock = tm_running
            & ((tm_time == `BRAC_TIME0) | (tm_time == `BRAC_TIME1))
            & (st.core_cycle_active_a | st.core_cycle_active_b);
        store_conflict_flag = core_write_lock & request_is_store
            & ~request_is_fetch;
    end

    // scheduled start: a register about to win this interval
    logic win_a; // a beats b in the core arbitration
    logic win_b; // b beats a
    logic can_set_a; // set prerequisites for a
    logic can_set_b;

    // core cycle set prerequisites and priority comparison
    always_comb begin
        // hold blocks store-to-core start until second word
        can_set_a = status_update_strobe & core_unit_free
            & ~st.core_cycle_active_b
            & (needs_core_fetch_a | (~hold_a & needs_store_a));
        can_set_b = status_update_strobe & core_unit_free
            & ~st.core_cycle_active_a
            & (needs_core_fetch_b | (~hold_b & needs_store_b));
        // a wins unless b's priority is higher; tie broken by pointer
        win_a = ~((prio_b[0] & prio_b[1]
                & (st.residence_pointer | ~prio_a[0]))
            | (prio_b[1] & ~prio_a[1])
            | (~prio_a[1] & st.residence_pointer)
            | (prio_b[1] & st.residence_pointer & ~prio_a[0]));
        win_b = ~win_a;
        core_start_scheduled_a = can_set_a & (st.core_cycle_active_a
            | ~(needs_core_fetch_b | (~hold_b & needs_store_b))
            | win_a);
        core_start_scheduled_b = can_set_b & ~core_start_scheduled_a
            & (st.core_cycle_active_b
            | ~(needs_core_fetch_a | (~hold_a & needs_store_a))
            | win_b);
        core_start = core_start_scheduled_a | core_start_scheduled_b;
    end

    // register choice
    logic rule12_a; // first criterion for a
    logic rule12_b;
    logic rule3_a; // second criterion prerequisites for a
    logic rule3_b;
    logic rule3x_a; // second criterion full decision for a
    logic rule3x_b;
    logic seq_pick_a; // flag pair decision favours a
    logic go; // request to this module without conflict
    logic blocked_a; // register may not be taken now
    logic blocked_b;

    always_comb begin
        go = module_request & ~store_conflict_flag;
        // never take a register in a core cycle, or held and sequential
        blocked_a = st.core_cycle_active_a | (hold_a & seq_a);
        blocked_b = st.core_cycle_active_b | (hold_b & seq_b);
        // flag pair: equal flags use pointer, else pick flagged one
        seq_pick_a = (~seq_b & ~st.residence_pointer) | (seq_a & ~seq_b)
            | (seq_a & ~st.residence_pointer);
        rule12_a = ~stale_a & ~hold_a & (st.core_cycle_active_b
            | stale_b | hold_b | seq_pick_a);
        rule12_b = ~stale_b & ~hold_b & (st.core_cycle_active_a
            | stale_a | hold_a | ~seq_pick_a);
        rule3_a = high_request & ~st.core_cycle_active_a
            & ~core_start_scheduled_a & ~seq_a & ~free_b
            & ~needs_store_a;
        rule3_b = high_request & ~st.core_cycle_active_b
            & ~core_start_scheduled_b & ~seq_b & ~free_a
            & ~needs_store_b;
        rule3x_a = rule3_a & (~st.residence_pointer
            | st.core_cycle_active_b | core_start_scheduled_b | seq_b
            | needs_core_fetch_b);
        rule3x_b = rule3_b & (st.residence_pointer
            | st.core_cycle_active_a | core_start_scheduled_a | seq_a
            | needs_core_fetch_a);
        choose_a = go & ~blocked_a & (rule12_a | rule3x_a);
        choose_b = go & ~blocked_b & ~choose_a
            & (rule12_b | (rule3x_b & ~rule3x_a));
        latch_status_a = choose_a;
        latch_status_b = choose_b;
        new_allocation_a = choose_a & ~match_a & ~match_b;
        new_allocation_b = choose_b & ~match_a & ~match_b;
        free_on_allocation = data_sample_phase & go
            & (free_a | free_b | rule3x_a | rule3x_b);
    end

    // core-to-register loads in intervals 3 or 4 of a running cycle
    logic fetch_window; // core read data available
    always_comb begin
        fetch_window = tm_running & ((tm_time == `BRAC_TIME3)
            | (tm_time == `BRAC_TIME4));
        core_to_register_load_a = (fetch_window & st.core_cycle_active_a)
            ? fetch_need_a : 2'h0;
        core_to_register_load_b = (fetch_window & st.core_cycle_active_b)
            ? fetch_need_b : 2'h0;
        // valid set by load only if not reassigned meanwhile
        set_valid_a = new_allocation_a ? 2'h0
            : (core_to_register_load_a | valid_a);
        set_valid_b = new_allocation_b ? 2'h0
            : (core_to_register_load_b | valid_b);
    end

    // port-to-register writes and data input strobes per half
    genvar h;
    generate
        for (h = 0; h < 2; h = h + 1) begin : g_half
            logic hit_half; // request targets this half
            logic store_half; // store into this half
            assign hit_half = (request_upper_half == 1'(h));
            assign store_half = request_is_store & hit_half;
            // new store into chosen a, or matching store
            assign port_to_register_write_a[h] =
                (choose_a & store_half & ~match_b)
                | (match_a & store_half);
            assign port_to_register_write_b[h] =
                (choose_b & store_half & ~match_a)
                | (match_b & store_half);
            // sample phase gates all transfers
            assign register_write_strobe_a[h] = data_sample_phase
                & (port_to_register_write_a[h]
                | core_to_register_load_a[h]);
            assign register_write_strobe_b[h] = data_sample_phase
                & (port_to_register_write_b[h]
                | core_to_register_load_b[h]);
        end
    endgenerate

    // active flag clear and next state
    logic clear_ok_time; // interval in which a clear may happen
    always_comb begin
        next_st = st;
        next_st.phase = status_update_strobe ? BRAC_PH_STATUS
            : BRAC_PH_SAMPLE;
        next_st.core_running = tm_running;
        next_st.core_time = tm_time;
        clear_ok_time = tm_running & ((tm_time == `BRAC_TIME1)
            | (tm_time == `BRAC_TIME4) | (tm_time == `BRAC_TIME5));
        // set wins; clear only at the status strobe
        if (core_start_scheduled_a) begin
            next_st.core_cycle_active_a = 1'h1;
        end else if (status_update_strobe & st.core_cycle_active_a
            & ((core_unit_free & ~tm_running)
            | (clear_ok_time & (&set_valid_a)))) begin
            next_st.core_cycle_active_a = 1'h0;
        end
        if (core_start_scheduled_b) begin
            next_st.core_cycle_active_b = 1'h1;
        end else if (status_update_strobe & st.core_cycle_active_b
            & ((core_unit_free & ~tm_running)
            | (clear_ok_time & (&set_valid_b)))) begin
            next_st.core_cycle_active_b = 1'h0;
        end
        // pointer follows a's new allocation
        if (new_allocation_a | new_allocation_b) begin
            next_st.residence_pointer = new_allocation_a;
        end
    end

    // state register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st.phase <= BRAC_PH_SAMPLE;
            st.core_cycle_active_a <= 1'h0;
            st.core_cycle_active_b <= 1'h0;
            st.residence_pointer <= `BRAC_PTR_RESET;
            st.core_running <= 1'h0;
            st.core_time <= `BRAC_TIME9;
        end else begin
            st <= next_st;
        end
    end

    // registered status outputs
    assign core_cycle_active_a = st.core_cycle_active_a;
    assign core_cycle_active_b = st.core_cycle_active_b;
    assign residence_pointer = st.residence_pointer;
    assign core_time_valid = st.core_running;
    assign core_time = st.core_time;

endmodule : brac_arbiter

// File: sim/brac_arbiter_sva.sv
/* checker for the register choice and core arbiter block.
 * assumes it is bound to brac_arbiter and sees its ports only. */
`timescale 1ns/10ps

module brac_arbiter_sva (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // request side
    input wire logic module_request,
    input wire logic request_is_store,
    input wire logic request_is_fetch,
    input wire logic request_upper_half,
    input wire logic match_a,
    input wire logic match_b,
    input wire logic hold_a,
    input wire logic seq_a,
    input wire logic core_unit_free,
    // design outputs
    input wire logic choose_a,
    input wire logic choose_b,
    input wire logic new_allocation_a,
    input wire logic new_allocation_b,
    input wire logic residence_pointer,
    input wire logic store_conflict_flag,
    input wire logic core_write_lock,
    input wire logic core_cycle_active_a,
    input wire logic core_cycle_active_b,
    input wire logic [1:0] core_to_register_load_a,
    input wire logic [1:0] register_write_strobe_a,
    input wire logic [1:0] port_to_register_write_a
);
    // one clock domain for all checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    property p_req;
        (choose_a || choose_b) |-> module_request && !store_conflict_flag;
    endproperty
    a_req: assert property (p_req) else $error("chosen unasked");
    property p_conflict;
        store_conflict_flag |->
            core_write_lock && request_is_store && !request_is_fetch;
    endproperty
    a_conflict: assert property (p_conflict) else $error("conflict");
    property p_blocked;
        (core_cycle_active_a || (hold_a && seq_a)) |-> !choose_a;
    endproperty
    a_blocked: assert property (p_blocked) else $error("busy a taken");
    property p_alloc;
        new_allocation_a == (choose_a && !match_a && !match_b);
    endproperty
    a_alloc: assert property (p_alloc) else $error("bad allocation");
    property p_ptr;
        (new_allocation_a || new_allocation_b) |=>
            residence_pointer == $past(new_allocation_a);
    endproperty
    a_ptr: assert property (p_ptr) else $error("pointer not loaded");
    property p_strobe;
        (|register_write_strobe_a) |=> register_write_strobe_a == 2'h0;
    endproperty
    a_strobe: assert property (p_strobe) else $error("strobe long");
    property p_source;
        register_write_strobe_a[1] |->
            port_to_register_write_a[1] || core_to_register_load_a[1];
    endproperty
    a_source: assert property (p_source) else $error("stray strobe");
    property p_set;
        $rose(core_cycle_active_a) |->
            $past(core_unit_free) && !$past(core_cycle_active_b);
    endproperty
    a_set: assert property (p_set) else $error("active set badly");
    property p_reset;
        $fell(rst) |-> !core_cycle_active_a && !core_cycle_active_b
            && !residence_pointer;
    endproperty
    a_reset: assert property (p_reset) else $error("reset state bad");
    property p_port;
        port_to_register_write_a[1] |-> request_is_store && request_upper_half;
    endproperty
    a_port: assert property (p_port) else $error("port write bad");
    // main scenarios reached
    c_choose: cover property (choose_a);
    c_alloc_b: cover property (new_allocation_b);
    c_core: cover property ($rose(core_cycle_active_a));
endmodule : brac_arbiter_sva

bind brac_arbiter brac_arbiter_sva chk_i (.*);

// File: sim/brac_core_model.sv
/* core module model: goes unavailable for one core cycle on a start.
 * assumes core_start is sampled on the rising ref_clk edge. */
`timescale 1ns/10ps

module brac_core_model #(parameter int BUSY_CLKS = 18) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // start from the arbiter
    input wire logic core_start,
    // availability back to the arbiter
    output logic core_unit_free
);
    int busy; // clocks left in the running cycle
    assign core_unit_free = (busy == 0);
    // a cycle lasts nine intervals of two clocks
    always @(posedge ref_clk) begin
        if (rst) begin
            busy <= 0;
        end else if (busy != 0) begin
            busy <= busy - 1;
        end else if (core_start) begin
            busy <= BUSY_CLKS;
        end
    end
endmodule : brac_core_model

// File: sim/buffer_register_assign_core_arbiter_test.sv
/* testbench for the register choice and core arbiter block.
 * assumes the core model file and the checker are compiled before. */
`timescale 1ns/10ps

module buffer_register_assign_core_arbiter_test;
    import brac_pkg::*;
    logic ref_clk, rst, module_request, request_is_store, request_is_fetch;
    logic request_upper_half, requested_prio_upper, requested_prio_lower;
    logic match_a, match_b, hold_a, seq_a, free_a, hold_b, seq_b, free_b;
    logic latched_prio_upper_a, latched_prio_lower_a, core_unit_free;
    logic latched_prio_upper_b, latched_prio_lower_b, core_start;
    logic [1:0] valid_a, current_a, valid_b, current_b;
    logic choose_a, choose_b, latch_status_a, latch_status_b;
    logic new_allocation_a, new_allocation_b, residence_pointer;
    logic free_on_allocation, store_conflict_flag, core_cycle_active_a;
    logic core_cycle_active_b, core_start_scheduled_a, core_start_scheduled_b;
    logic core_write_lock, core_read_lock, core_time_valid;
    logic [1:0] core_to_register_load_a, core_to_register_load_b;
    logic [1:0] set_valid_a, set_valid_b, register_write_strobe_a;
    logic [1:0] register_write_strobe_b, port_to_register_write_a;
    logic [1:0] port_to_register_write_b;
    logic [3:0] core_time;
    int n_errors = 0;
    int checks_done = 0;
    int k;
    brac_arbiter dut (.*);
    brac_core_model far_core (.ref_clk(ref_clk), .rst(rst),
        .core_start(core_start), .core_unit_free(core_unit_free));

    // 50 ns clock
    always #25 ref_clk = ~ref_clk;
    task automatic chk(input string what, input logic [3:0] exp,
                       input logic [3:0] got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic finish_test();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finish_test

    // f = hold_a, seq_a, hold_b, seq_b, urgent, free_b, b in use
    task automatic try_a(input logic [6:0] f, input logic exp);
        @(negedge ref_clk);
        {hold_a, seq_a, hold_b, seq_b} = f[6:3];
        {requested_prio_upper, requested_prio_lower} = {2{f[2]}};
        free_b = f[1];
        valid_b = {1'b0, f[0]};
        #1;
        chk("choose_a", exp, choose_a);
        chk("latch_status_a", exp, latch_status_a);
    endtask : try_a

    task automatic table_pass(input logic p);
        for (int i = 0; i < 4; i++) begin
            try_a({1'b0, i[1], 1'b0, i[0], 3'h0},
                (!i[0] && !p) || (i[1] && !i[0]) || (i[1] && !p));
        end
    endtask : table_pass

    // hang guard
    initial begin
        #(50 * 4000);
        n_errors++;
        finish_test();
    end

    initial begin
        ref_clk = 0;
        rst = 1;
        {module_request, request_is_store, request_upper_half} = 3'h0;
        {requested_prio_upper, requested_prio_lower, match_a} = 3'h0;
        {match_b, hold_a, seq_a, free_a, hold_b, seq_b, free_b} = 7'h00;
        {latched_prio_upper_a, latched_prio_lower_a} = 2'h0;
        {latched_prio_upper_b, latched_prio_lower_b} = 2'h0;
        {valid_a, current_a, valid_b, current_b} = 8'h00;
        request_is_fetch = 1;
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        rst = 0;
        // fetch hitting a keeps the pointer still
        module_request = 1;
        match_a = 1;
        #1;
        chk("pointer", 0, residence_pointer);
        chk("active", 0, {core_cycle_active_a, core_cycle_active_b});
        table_pass(0);
        // new allocation of a sets the pointer
        @(negedge ref_clk);
        match_a = 0;
        #1;
        chk("new_allocation_a", 1, new_allocation_a);
        @(negedge ref_clk);
        match_a = 1;
        chk("pointer", 1, residence_pointer);
        table_pass(1);
        @(negedge ref_clk);
        match_a = 0;
        #1;
        chk("new_allocation_b", 1, new_allocation_b);
        @(negedge ref_clk);
        match_a = 1;
        chk("pointer", 0, residence_pointer);
        // choice of a under flag pair, hold and urgent cases; held and sequential registers are never taken
        try_a(7'h60, 0);
        try_a(7'h08, 0);
        try_a(7'h28, 1);
        try_a(7'h09, 1);
        try_a(7'h40, 0);
        try_a(7'h44, 1);
        try_a(7'h46, 0);
        try_a(7'h78, 0);
        chk("choose_b", 0, choose_b);
        try_a(7'h00, 1);
        @(negedge ref_clk);
        module_request = 0;
        #1;
        chk("choose", 0, {choose_a, choose_b, free_on_allocation});
        // upper store: new then matching
        @(negedge ref_clk);
        {module_request, request_is_store, request_is_fetch} = 3'h6;
        {request_upper_half, match_a} = 2'h2;
        #1;
        chk("port_write_new", 2'h2, port_to_register_write_a);
        @(negedge ref_clk);
        match_a = 1;
        k = 0;
        repeat (2) begin
            @(negedge ref_clk);
            chk("port_write_match", 2'h2, port_to_register_write_a);
            k += (register_write_strobe_a === 2'h2);
        end
        chk("strobe_count", 1, k[3:0]);
        // lower half needs a core fetch
        @(negedge ref_clk);
        {module_request, request_is_store, request_is_fetch} = 3'h1;
        current_a = 2'h1;
        for (k = 0; k < 20 && core_cycle_active_a !== 1'b1; k++)
            @(negedge ref_clk);
        chk("active_a", 1, core_cycle_active_a);
        chk("active_b", 0, core_cycle_active_b);
        for (k = 0; k < 40 && set_valid_a[0] !== 1'b1; k++)
            @(negedge ref_clk);
        chk("load_a", 1, core_to_register_load_a[0]);
        chk("write_lock", 1, core_write_lock);
        @(negedge ref_clk);
        {valid_a, current_a} = 4'hf;
        for (k = 0; k < 10 && core_cycle_active_a !== 1'b0; k++)
            @(negedge ref_clk);
        chk("active_a_clear", 0, core_cycle_active_a);
        chk("core_time", 4'h4, core_time);
        finish_test();
    end
endmodule : buffer_register_assign_core_arbiter_test
